// ### hdl/rlm_node.sv
// Loop multiplexer node: input and output loop sections, adapter bus
//
// Contract
// - Take input loop cells in parallel from upstream node or interface.
// - While input section unlocked, forward every cell unchanged.
// - Regenerate the loop clock cleanly for the next ring element.
// - Lock only on a loop-end cell directly followed by an empty cell.
// - Holding data, seize loop end, send frames, then reinsert loop end.
// - Once locked, collect each requester's data and send it framed.
// - At each frame boundary, an empty incoming cell gets the next frame.
// - A non-empty cell at a frame boundary drops lock.
// - Grant one adapter of 32 lines; it drives the bus on strobes.
// - Take bytes until information end or 16 cells, whichever first.
// - After a transfer, release the adapter and select another requester.
// - Drop lock when no unserved requesters remain.
// - Output section always forwards every received cell.
// - Output section locks to the stream on empty cells.
// - Locked output section finds frames and delivers their cells.
// - Check the check character that ends every frame.
// - Broadcast a captured frame address to all adapters.
// - Report a check mismatch to the adapter before disconnecting it.
// - Adapter data moves as 8-bit bytes both ways.
`timescale 1ns/1ps
`include "rlm_defs.svh"

module rlm_node import rlm_pkg::*; #(
  parameter int unsigned MAX_CELLS = `RLM_MAX_CELLS,
  parameter logic [7:0]  CRC_POLY  = `RLM_CRC_POLY
) (
  input  logic                    i_clk,
  input  logic                    i_reset,
  input  logic                    i_loop_clk,
  input  rlm_cell_t               i_iin,
  output rlm_cell_t               o_iout,
  input  rlm_cell_t               i_oin,
  output rlm_cell_t               o_oout,
  output logic                    o_loop_clk,
  input  logic [`RLM_N_ADAPT-1:0] i_req,
  output logic [`RLM_N_ADAPT-1:0] o_grant,
  output logic                    o_strobe,
  input  logic                    i_ad_ack,
  input  logic                    i_ad_last,
  input  logic [`RLM_BYTE_W-1:0]  i_ad_data,
  output rlm_obus_t               o_obus,
  output logic                    o_in_sync,
  output logic                    o_out_sync
);

  localparam int CNTW = $clog2(MAX_CELLS + 2);
  localparam int ADW  = 2 + `RLM_BYTE_W;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [`RLM_N_ADAPT-1:0] req_s1, req_s2;
  logic [ADW-1:0]          ad_s1, ad_s2;
  logic                    ack_s, last_s;
  logic [7:0]              data_s;

  rlm_fstate_t             f_state, next_f_state;
  logic [`RLM_ADDR_W-1:0]  g_idx, next_g_idx;
  logic [`RLM_N_ADAPT-1:0] grant, next_grant;
  logic                    strobe, next_strobe;
  logic                    fin, next_fin;
  logic [CNTW-1:0]         cnt, next_cnt;
  logic [CNTW-1:0]         len, next_len;
  logic [`RLM_N_ADAPT-1:0] served, next_served;
  logic [7:0]              fbuf [MAX_CELLS];
  logic [7:0]              next_fbuf [MAX_CELLS];
  logic [`RLM_ADDR_W:0]    pick_res;
  logic                    any_unserved;

  rlm_estate_t             e_state, next_e_state;
  rlm_cell_t               p, next_p;
  rlm_cell_t               iout, next_iout;
  logic [CNTW-1:0]         e_idx, next_e_idx;
  logic [7:0]              e_crc, next_e_crc;
  logic                    in_sync, next_in_sync;
  logic                    taken, unlock, start;
  rlm_cell_t               head;

  rlm_cell_t               oout, next_oout;
  logic                    osync, next_osync;
  logic                    in_frame, next_in_frame;
  logic                    end_pend, next_end_pend;
  logic [7:0]              ocrc, next_ocrc;
  rlm_obus_t               obus, next_obus;

  // ----------------------------------------------------------------------
  // Clock regeneration
  // ----------------------------------------------------------------------
  rlm_clk_regen u_regen (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_loop_clk (i_loop_clk),
    .o_loop_clk (o_loop_clk)
  );

  // ----------------------------------------------------------------------
  // Adapter pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_loop_clk or posedge i_reset) begin
    if (i_reset) begin
      req_s1 <= '0;
      req_s2 <= '0;
      ad_s1  <= '0;
      ad_s2  <= '0;
    end else begin
      req_s1 <= i_req;
      req_s2 <= req_s1;
      ad_s1  <= {i_ad_ack, i_ad_last, i_ad_data};
      ad_s2  <= ad_s1;
    end
  end

  assign {ack_s, last_s, data_s} = ad_s2;

  // Lowest index wins; fairness comes from the served mask per lock
  function automatic logic [`RLM_ADDR_W:0] pick(
      input logic [`RLM_N_ADAPT-1:0] m);
    logic [`RLM_ADDR_W:0] r;
    r = '0;
    for (int i = `RLM_N_ADAPT - 1; i >= 0; i--) begin
      if (m[i]) r = {1'b1, i[`RLM_ADDR_W-1:0]};
    end
    return r;
  endfunction : pick

  assign pick_res     = pick(req_s2 & ~served);
  assign any_unserved = pick_res[`RLM_ADDR_W];

  // ----------------------------------------------------------------------
  // Adapter fetch: fills the staging frame
  // ----------------------------------------------------------------------
  always_comb begin
    next_f_state = f_state;
    next_g_idx   = g_idx;
    next_grant   = grant;
    next_strobe  = strobe;
    next_fin     = fin;
    next_cnt     = cnt;
    next_len     = len;
    next_fbuf    = fbuf;
    next_served  = unlock ? '0 : served;
    case (f_state)
      F_IDLE: begin
        if (any_unserved) begin
          next_g_idx   = pick_res[`RLM_ADDR_W-1:0];
          next_grant   = '0;
          next_grant[pick_res[`RLM_ADDR_W-1:0]] = 1'b1;
          next_strobe  = 1'b1;
          next_cnt     = '0;
          next_fin     = 1'b0;
          next_f_state = F_STRB;
        end
      end
      F_STRB: begin
        if (ack_s) begin
          next_fbuf[cnt[$clog2(MAX_CELLS)-1:0]] = data_s;
          next_cnt     = cnt + 1'b1;
          next_len     = cnt + 1'b1;
          next_fin     = last_s || (cnt == CNTW'(MAX_CELLS - 1));
          next_strobe  = 1'b0;
          next_f_state = F_DROP;
        end
      end
      F_DROP: begin
        if (!ack_s) begin
          if (fin) begin
            next_grant   = '0;
            next_served[g_idx] = 1'b1;
            next_f_state = F_RDY;
          end else begin
            next_strobe  = 1'b1;
            next_f_state = F_STRB;
          end
        end
      end
      F_RDY: begin
        if (taken) next_f_state = F_IDLE;
      end
      default: next_f_state = F_IDLE;
    endcase
  end

  always_ff @(posedge i_loop_clk or posedge i_reset) begin
    if (i_reset) begin
      f_state <= F_IDLE;
      g_idx   <= '0;
      grant   <= '0;
      strobe  <= 1'b0;
      fin     <= 1'b0;
      cnt     <= '0;
      len     <= '0;
      served  <= '0;
      for (int i = 0; i < MAX_CELLS; i++) fbuf[i] <= 8'h00;
    end else begin
      f_state <= next_f_state;
      g_idx   <= next_g_idx;
      grant   <= next_grant;
      strobe  <= next_strobe;
      fin     <= next_fin;
      cnt     <= next_cnt;
      len     <= next_len;
      served  <= next_served;
      fbuf    <= next_fbuf;
    end
  end

  // ----------------------------------------------------------------------
  // Input loop section
  // ----------------------------------------------------------------------
  // While locked, p holds the seized loop end; inside a frame the
  // incoming cells are taken as empty and overwritten unchecked
  always_comb begin
    next_e_state = e_state;
    next_p       = i_iin;
    next_iout    = p;
    next_e_idx   = e_idx;
    next_e_crc   = e_crc;
    taken        = 1'b0;
    unlock       = 1'b0;
    start        = 1'b0;
    head.kind    = `RLM_K_HEAD;
    head.data    = {3'h0, g_idx};
    case (e_state)
      E_HUNT: begin
        if (p.kind == `RLM_K_LEND && i_iin.kind == `RLM_K_EMPTY &&
            f_state == F_RDY) begin
          start = 1'b1;
        end
      end
      E_BOUND: begin
        next_p = p;
        if (i_iin.kind != `RLM_K_EMPTY) begin
          unlock = 1'b1;
        end else if (f_state == F_RDY) begin
          start = 1'b1;
        end else if (f_state != F_IDLE || any_unserved) begin
          next_iout.kind = `RLM_K_EMPTY;
          next_iout.data = 8'h00;
        end else begin
          unlock = 1'b1;
        end
      end
      E_SEND: begin
        next_p = p;
        if (e_idx <= len) begin
          next_iout.kind = `RLM_K_DATA;
          next_iout.data = fbuf[e_idx[$clog2(MAX_CELLS)-1:0] - 1'b1];
          next_e_crc     = rlm_crc8(e_crc, next_iout.data, CRC_POLY);
          next_e_idx     = e_idx + 1'b1;
        end else begin
          next_iout.kind = `RLM_K_CRC;
          next_iout.data = e_crc;
          taken          = 1'b1;
          next_e_state   = E_BOUND;
        end
      end
      default: next_e_state = E_HUNT;
    endcase
    if (start) begin
      next_p       = p;
      next_iout    = head;
      next_e_idx   = CNTW'(1);
      next_e_crc   = rlm_crc8(`RLM_CRC_INIT, head.data, CRC_POLY);
      next_e_state = E_SEND;
    end
    if (unlock) begin
      next_p       = i_iin;
      next_iout    = p;
      next_e_state = E_HUNT;
    end
    next_in_sync = (next_e_state != E_HUNT);
  end

  always_ff @(posedge i_loop_clk or posedge i_reset) begin
    if (i_reset) begin
      e_state <= E_HUNT;
      p       <= '0;
      iout    <= '0;
      e_idx   <= '0;
      e_crc   <= 8'h00;
      in_sync <= 1'b0;
    end else begin
      e_state <= next_e_state;
      p       <= next_p;
      iout    <= next_iout;
      e_idx   <= next_e_idx;
      e_crc   <= next_e_crc;
      in_sync <= next_in_sync;
    end
  end

  // ----------------------------------------------------------------------
  // Output loop section
  // ----------------------------------------------------------------------
  always_comb begin
    next_oout          = i_oin;
    next_osync         = osync;
    next_in_frame      = in_frame;
    next_end_pend      = 1'b0;
    next_ocrc          = ocrc;
    next_obus          = obus;
    next_obus.strobe   = 1'b0;
    next_obus.crc_err  = 1'b0;
    if (end_pend) next_obus.addr_valid = 1'b0;
    if (!osync) begin
      if (i_oin.kind == `RLM_K_EMPTY) next_osync = 1'b1;
    end else begin
      case (i_oin.kind)
        `RLM_K_EMPTY, `RLM_K_LEND: begin
          if (in_frame) begin
            next_in_frame        = 1'b0;
            next_obus.addr_valid = 1'b0;
          end
        end
        `RLM_K_HEAD: begin
          next_in_frame        = 1'b1;
          next_obus.addr       = i_oin.data;
          next_obus.addr_valid = 1'b1;
          next_ocrc = rlm_crc8(`RLM_CRC_INIT, i_oin.data, CRC_POLY);
        end
        `RLM_K_DATA: begin
          if (in_frame) begin
            next_obus.data   = i_oin.data;
            next_obus.strobe = 1'b1;
            next_ocrc        = rlm_crc8(ocrc, i_oin.data, CRC_POLY);
          end else begin
            next_osync = 1'b0;
          end
        end
        `RLM_K_CRC: begin
          if (in_frame) begin
            next_obus.crc_err = (i_oin.data != ocrc);
            next_end_pend     = 1'b1;
            next_in_frame     = 1'b0;
          end else begin
            next_osync = 1'b0;
          end
        end
        default: begin
          next_osync           = 1'b0;
          next_in_frame        = 1'b0;
          next_obus.addr_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_loop_clk or posedge i_reset) begin
    if (i_reset) begin
      oout     <= '0;
      osync    <= 1'b0;
      in_frame <= 1'b0;
      end_pend <= 1'b0;
      ocrc     <= 8'h00;
      obus     <= '0;
    end else begin
      oout     <= next_oout;
      osync    <= next_osync;
      in_frame <= next_in_frame;
      end_pend <= next_end_pend;
      ocrc     <= next_ocrc;
      obus     <= next_obus;
    end
  end

  assign o_iout     = iout;
  assign o_oout     = oout;
  assign o_grant    = grant;
  assign o_strobe   = strobe;
  assign o_obus     = obus;
  assign o_in_sync  = in_sync;
  assign o_out_sync = osync;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_loop_clk); endclocking
  default disable iff (i_reset);

  sequence s_lock;
    e_state == E_HUNT ##1 e_state == E_SEND;
  endsequence

  sequence s_release;
    e_state != E_HUNT ##1 e_state == E_HUNT;
  endsequence

  a_in_transparent: assert property (
    (e_state == E_HUNT && !start) |=> o_iout == $past(p))
    else $error("unlocked input section altered a cell");
  a_lock_pair: assert property (
    s_lock |-> $past(i_iin.kind) == `RLM_K_EMPTY &&
               $past(p.kind) == `RLM_K_LEND && o_iout.kind == `RLM_K_HEAD)
    else $error("lock taken without loop end and empty cell");
  a_lend_reinsert: assert property (
    s_release |-> o_iout.kind == `RLM_K_LEND)
    else $error("loop end not reinserted on release");
  a_bound_insert: assert property (
    (e_state == E_BOUND && i_iin.kind == `RLM_K_EMPTY && f_state == F_RDY)
    |=> o_iout.kind == `RLM_K_HEAD && e_state == E_SEND)
    else $error("empty boundary cell not replaced by frame");
  a_bound_busy: assert property (
    (e_state == E_BOUND && i_iin.kind != `RLM_K_EMPTY)
    |=> e_state == E_HUNT && o_in_sync == 1'b0)
    else $error("busy boundary cell did not drop lock");
  a_none_left: assert property (
    (e_state == E_BOUND && i_iin.kind == `RLM_K_EMPTY &&
     f_state == F_IDLE && !any_unserved) |=> e_state == E_HUNT)
    else $error("lock kept with nobody left to serve");
  a_grant_single: assert property (
    $onehot0(o_grant) && (!o_strobe || o_grant != '0))
    else $error("grant lines not single or strobe without grant");
  a_cell_limit: assert property (
    (f_state == F_STRB) |-> cnt < CNTW'(MAX_CELLS))
    else $error("adapter cell limit exceeded");
  a_count_restart: assert property (
    (f_state == F_IDLE ##1 f_state == F_STRB) |-> cnt == '0)
    else $error("cell count not restarted on selection");
  a_release_grant: assert property (
    (f_state == F_DROP && fin && !ack_s) |=> o_grant == '0 && served[g_idx])
    else $error("finished adapter not released");
  a_out_forward: assert property (
    !$past(i_reset) |-> o_oout == $past(i_oin))
    else $error("output loop cell not forwarded");
  a_out_lock: assert property (
    $rose(o_out_sync) |-> $past(i_oin.kind) == `RLM_K_EMPTY)
    else $error("output section locked without empty cell");
  a_addr_bcast: assert property (
    (osync && i_oin.kind == `RLM_K_HEAD)
    |=> o_obus.addr_valid && o_obus.addr == $past(i_oin.data))
    else $error("frame address not broadcast");
  a_err_then_end: assert property (
    o_obus.crc_err |-> o_obus.addr_valid ##1
      (!o_obus.addr_valid || $past(i_oin.kind) == `RLM_K_HEAD))
    else $error("check error not reported before disconnect");

endmodule : rlm_node

// ### shared/rlm_defs.svh
// Constants of the ring loop multiplexer node
`ifndef RLM_DEFS_SVH
`define RLM_DEFS_SVH

// ----------------------------------------------------------------------
// Cell format
// ----------------------------------------------------------------------
`define RLM_KIND_W      3
`define RLM_BYTE_W      8
`define RLM_K_EMPTY     3'h0
`define RLM_K_LEND      3'h1
`define RLM_K_HEAD      3'h2
`define RLM_K_DATA      3'h3
`define RLM_K_CRC       3'h4

// ----------------------------------------------------------------------
// Adapter side and frame limits
// ----------------------------------------------------------------------
`define RLM_N_ADAPT     32
`define RLM_ADDR_W      5
`define RLM_MAX_CELLS   16

// ----------------------------------------------------------------------
// Frame check character
// ----------------------------------------------------------------------
`define RLM_CRC_POLY    8'h07
`define RLM_CRC_INIT    8'h00

`endif

// ### shared/rlm_pkg.sv
// Types and the check-character function of the loop multiplexer node
`include "rlm_defs.svh"

package rlm_pkg;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`RLM_KIND_W-1:0] kind;
    logic [`RLM_BYTE_W-1:0] data;
  } rlm_cell_t;

  typedef struct packed {
    logic [`RLM_BYTE_W-1:0] addr;
    logic                   addr_valid;
    logic [`RLM_BYTE_W-1:0] data;
    logic                   strobe;
    logic                   crc_err;
  } rlm_obus_t;

  // ----------------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    E_HUNT  = 2'b00,
    E_BOUND = 2'b01,
    E_SEND  = 2'b10
  } rlm_estate_t;

  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_STRB = 2'b01,
    F_DROP = 2'b10,
    F_RDY  = 2'b11
  } rlm_fstate_t;

  // ----------------------------------------------------------------------
  // Check character, msb first
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rlm_crc8(input logic [7:0] crc,
                                          input logic [7:0] d,
                                          input logic [7:0] poly);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ poly) : (c << 1);
    end
    return c;
  endfunction : rlm_crc8

endpackage : rlm_pkg

// ### hdl/rlm_clk_regen.sv
// Loop clock regeneration on the node's own clock
`timescale 1ns/1ps

module rlm_clk_regen (
  input  logic i_clk,
  input  logic i_reset,
  input  logic i_loop_clk,
  output logic o_loop_clk
);

  logic sync1;
  logic sync2;
  logic clk_out;
  logic next_sync1;
  logic next_sync2;
  logic next_clk_out;

  // ----------------------------------------------------------------------
  // Resample and redrive
  // ----------------------------------------------------------------------
  // Edges come out on the node clock grid, clean and full swing
  always_comb begin
    next_sync1   = i_loop_clk;
    next_sync2   = sync1;
    next_clk_out = sync2;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1   <= 1'b0;
      sync2   <= 1'b0;
      clk_out <= 1'b0;
    end else begin
      sync1   <= next_sync1;
      sync2   <= next_sync2;
      clk_out <= next_clk_out;
    end
  end

  assign o_loop_clk = clk_out;

endmodule : rlm_clk_regen

// ### bench/rlm_adapter_model.sv
// Line adapter group model facing the node's adapter bus
`timescale 1ns/1ps

module rlm_adapter_model import rlm_pkg::*; (
  input  wire logic        i_lclk,
  input  wire logic        i_reset,
  input  wire logic [31:0] i_want,
  input  wire logic [4:0]  i_len,
  input  wire logic [31:0] i_grant,
  input  wire logic        i_strobe,
  output logic      [31:0] o_req,
  output logic             o_ack,
  output logic             o_last,
  output logic      [7:0]  o_data
);
  logic [31:0] done;
  logic [4:0]  cnt;
  logic [1:0]  ph;
  int          k;

  assign o_req = i_want & ~done;
  always_comb begin
    k = 0;
    for (int i = 0; i < 32; i++) if (i_grant[i]) k = i;
  end
  // Data settles a cycle before ack and stays until ack falls
  always @(posedge i_lclk or posedge i_reset) begin
    if (i_reset) begin
      done <= '0;
      cnt <= '0;
      ph <= '0;
      o_ack <= 1'b0;
      o_last <= 1'b0;
      o_data <= '0;
    end else begin
      done <= done & i_want;
      if (i_grant == '0) cnt <= '0;
      case (ph)
        2'h0: if (i_strobe && i_grant != '0) begin
          o_data <= 8'(k * 16 + cnt);
          o_last <= (cnt == i_len - 5'h1);
          ph <= 2'h1;
        end
        2'h1: begin
          o_ack <= 1'b1;
          if (o_last || cnt == 5'hf) done[k] <= 1'b1;
          ph <= 2'h2;
        end
        default: if (!i_strobe) begin
          o_ack <= 1'b0;
          o_data <= ~o_data; // Released bus no longer shows the byte
          cnt <= cnt + 5'h1;
          ph <= 2'h0;
        end
      endcase
    end
  end
endmodule : rlm_adapter_model

// ### bench/rlm_node_tb_top.sv
// Self-checking bench of the loop multiplexer node
`timescale 1ns/1ps
`include "rlm_defs.svh"

module rlm_node_tb_top import rlm_pkg::*;;
  logic        clk = 0, lclk = 0, rst = 1;
  rlm_cell_t   iin, oin, iout, oout;
  rlm_obus_t   obus;
  logic [31:0] want, req, grant;
  logic [4:0]  len;
  logic        strobe, ack, last, lclk_o, isync, osync;
  logic [7:0]  adata;
  int          n_mismatch = 0, checks = 0;
  rlm_cell_t   expq[$], got[$];

  initial forever #12.5 clk = ~clk;
  initial #3 forever #80 lclk = ~lclk;

  rlm_node i_dut (.i_clk(clk), .i_reset(rst), .i_loop_clk(lclk),
    .i_iin(iin), .o_iout(iout), .i_oin(oin), .o_oout(oout),
    .o_loop_clk(lclk_o), .i_req(req), .o_grant(grant), .o_strobe(strobe),
    .i_ad_ack(ack), .i_ad_last(last), .i_ad_data(adata), .o_obus(obus),
    .o_in_sync(isync), .o_out_sync(osync));
  rlm_adapter_model i_ads (.i_lclk(lclk), .i_reset(rst), .i_want(want),
    .i_len(len), .i_grant(grant), .i_strobe(strobe), .o_req(req),
    .o_ack(ack), .o_last(last), .o_data(adata));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input rlm_cell_t c);
    @(negedge lclk);
    iin = c;
  endtask : cyc

  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    repeat (8) c = c[7] ? ((c << 1) ^ `RLM_CRC_POLY) : (c << 1);
    return c;
  endfunction : crc

  task automatic add_frame(input int k, input int l);
    logic [7:0] c, d;
    c = crc(`RLM_CRC_INIT, 8'(k));
    expq.push_back({`RLM_K_HEAD, 8'(k)});
    for (int n = 0; n < l && n < `RLM_MAX_CELLS; n++) begin
      d = 8'(k * 16 + n);
      c = crc(c, d);
      expq.push_back({`RLM_K_DATA, d});
    end
    expq.push_back({`RLM_K_CRC, c});
  endtask : add_frame

  // Idle loop long enough for the next frame to be staged
  task automatic stage();
    for (int n = 0; n < 500; n++) begin
      cyc({`RLM_K_EMPTY, 8'h00});
      if (grant === '0 && n > 200) break;
    end
  endtask : stage

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic run(input logic [2:0] fill);
    bit on;
    on = 0;
    got = {};
    cyc({`RLM_K_LEND, 8'h00});
    for (int n = 0; n < 600; n++) begin
      cyc({n == 0 ? `RLM_K_EMPTY : fill, 8'h00});
      if (isync === 1'b1) on = 1;
      if (on && iout.kind === `RLM_K_LEND) break;
      if (on && iout.kind !== `RLM_K_EMPTY) got.push_back(iout);
    end
    chk(isync, 0);
    chk(got.size(), expq.size());
    foreach (expq[i]) chk(got[i], expq[i]);
    expq = {};
  endtask : run

  task automatic t_fwd();
    logic [10:0] s[6];
    s = '{11'h100, 11'h33c, 11'h211, 11'h7a5, 11'h40f, 11'h000};
    for (int j = 0; j < 8; j++) begin
      cyc(j < 6 ? s[j] : 11'h000);
      if (j >= 2) chk(iout, s[j - 2]);
      chk(isync, 0);
    end
  endtask : t_fwd

  task automatic t_out();
    logic [10:0] s[8];
    logic [7:0]  g;
    g = crc(crc(`RLM_CRC_INIT, 8'h09), 8'h5a);
    s = '{11'h000, 11'h209, 11'h35a, {3'h4, g}, 11'h207, 11'h3a5,
          {3'h4, ~g}, 11'h000};
    // A data cell outside a frame drops lock, so the lock below is fresh
    @(negedge lclk);
    oin = 11'h300;
    for (int j = 0; j < 9; j++) begin
      @(negedge lclk);
      if (j > 0) chk(oout, s[j - 1]);
      case (j)
        0: chk(osync, 0);
        1: chk(osync, 1);
        2: chk({obus.addr_valid, obus.addr}, 9'h109);
        3: chk({obus.strobe, obus.data}, 9'h15a);
        4: chk(obus.crc_err, 0);
        7: chk({obus.crc_err, obus.addr_valid}, 2'b11);
        8: chk(obus.addr_valid, 0);
        default: ;
      endcase
      if (j < 8) oin = s[j];
    end
  endtask : t_out

  task automatic t_clk();
    @(posedge lclk);
    #80 chk(lclk_o, 1);
    #78 chk(lclk_o, 0);
  endtask : t_clk

  task automatic give_verdict();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    #2000000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    iin = '0;
    oin = '0;
    want = '0;
    len = 5'd2;
    repeat (10) @(negedge clk);
    rst = 0;
    want = 32'h8;
    stage();
    t_fwd();
    add_frame(3, 2);
    run(`RLM_K_EMPTY);
    want = '0;
    cyc({`RLM_K_EMPTY, 8'h00});
    want = 32'h14;
    len = 5'd1;
    add_frame(2, 1);
    stage();
    run(`RLM_K_DATA);
    add_frame(4, 1);
    stage();
    run(`RLM_K_EMPTY);
    want = '0;
    cyc({`RLM_K_EMPTY, 8'h00});
    want = 32'h22;
    len = 5'd20;
    add_frame(1, 20);
    add_frame(5, 20);
    stage();
    run(`RLM_K_EMPTY);
    t_out();
    t_clk();
    give_verdict();
  end
endmodule : rlm_node_tb_top
